// ===== core/cmd_cond_pkg.sv
// package: register map, field codes and timing constants for the block
package cmd_cond_pkg;

  // ******************************************************
  // register map (byte addresses, word aligned)
  // ******************************************************
  localparam logic [7:0] ADDR_CLR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_INH_CFG    = 8'h04;
  localparam logic [7:0] ADDR_UNIT_SEL   = 8'h08;
  localparam logic [7:0] ADDR_TRQ_LIM2   = 8'h0c;
  localparam logic [7:0] ADDR_RATE_MAX   = 8'h10;
  localparam logic [7:0] ADDR_REGEN_EN   = 8'h14;
  localparam logic [7:0] ADDR_VDEV_THR   = 8'h18;
  localparam logic [7:0] ADDR_G3_TIME    = 8'h1c;
  localparam logic [7:0] ADDR_G3_SCALE   = 8'h20;
  localparam logic [7:0] ADDR_TRQ_OFS    = 8'h24;
  localparam logic [7:0] ADDR_TRQ_POS    = 8'h28;
  localparam logic [7:0] ADDR_TRQ_NEG    = 8'h2c;
  localparam logic [7:0] ADDR_ESTOP_MS   = 8'h30;
  localparam logic [7:0] ADDR_GEN_FILT   = 8'h34;
  localparam logic [7:0] ADDR_MOTOR_MAX  = 8'h38;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h40;
  localparam logic [7:0] ADDR_IRQ_CLR    = 8'h44;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h48;
  localparam logic [7:0] ADDR_LIVE       = 8'h4c;
  localparam logic [7:0] ADDR_RATE_MEAS  = 8'h50;
  localparam logic [7:0] ADDR_ESTOP_Q    = 8'h54;
  localparam logic [7:0] ADDR_G3_GAIN    = 8'h58;
  localparam logic [7:0] ADDR_TRQ_OUT    = 8'h5c;
  localparam logic [31:0] BAD_ADDR_DATA  = 32'hdeadbeef;

  // ******************************************************
  // field codes and reset values
  // ******************************************************
  localparam logic [2:0]  CLR_OFF        = 3'h0;
  localparam logic [2:0]  CLR_LVL_RAW    = 3'h1;
  localparam logic [2:0]  CLR_LVL_FLT    = 3'h2;
  localparam logic [2:0]  CLR_EDG_RAW    = 3'h3;
  localparam logic [2:0]  CLR_EDG_FLT    = 3'h4;
  localparam logic [2:0]  INH_RATE_RAW   = 3'h4;
  localparam logic [12:0] RATE_MAX_RST   = 13'h0fa0;
  localparam logic [12:0] RATE_MAX_MIN   = 13'h00fa;
  localparam logic [10:0] G3_SCALE_MIN   = 11'h032;
  localparam logic [10:0] G3_SCALE_MAX   = 11'h3e8;
  localparam logic [10:0] G3_SCALE_RST   = 11'h064;
  localparam logic [15:0] G1_GAIN_RST    = 16'h01e0;
  localparam logic [9:0]  ESTOP_MAX      = 10'h3e8;
  localparam logic [13:0] G3_TIME_MAX    = 14'h2710;
  localparam logic [14:0] VDEV_MAX       = 15'h4e20;
  localparam logic [8:0]  TRQ_LIM_MAX    = 9'h1f4;
  localparam logic [7:0]  TRQ_PCT_MAX    = 8'h64;
  localparam logic [8:0]  MOTOR_MAX_RST  = 9'h12c;
  localparam logic [13:0] PCT_DIV        = 14'h0064;

  // interrupt status bit positions
  localparam int IRQ_RATE  = 0;
  localparam int IRQ_REGEN = 1;
  localparam int IRQ_VDEV  = 2;
  localparam int IRQ_CLR   = 3;
  localparam int IRQ_W     = 4;

  // ******************************************************
  // timing: clock is 20 MHz, 50 ns
  // ******************************************************
  localparam int CLK_HZ       = 20_000_000;
  localparam int T0_NS        = 166_000;
  localparam int T1_NS        = 333_000;
  localparam int T2_NS        = 1_000_000;
  localparam int T3_NS        = 1_666_000;
  localparam int TICK_NS      = 100_000;  // 0.1 ms gain time unit
  localparam int MS_NS        = 1_000_000;
  localparam int CLK_NS       = 1_000_000_000 / CLK_HZ;
  localparam int T0_CYC       = T0_NS / CLK_NS;
  localparam int T1_CYC       = T1_NS / CLK_NS;
  localparam int T2_CYC       = T2_NS / CLK_NS;
  localparam int T3_CYC       = T3_NS / CLK_NS;
  localparam int TICK_CYC     = TICK_NS / CLK_NS;
  localparam int MS_CYC       = MS_NS / CLK_NS;
  localparam int ESTOP_STEP   = 2;        // emergency-stop resolution, ms

  typedef enum logic [1:0] {
    G_FIRST = 2'b00,
    G_THIRD = 2'b01,
    G_SECOND = 2'b10
  } gain_state_t;

  // avalon-mm request carrier
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } av_req_t;

endpackage : cmd_cond_pkg

// ===== core/cmd_cond.sv
// command-pulse conditioning and protection settings, avalon-mm slave
//
// What this block does
// - clear input qualified by five-way mode
// - inhibit input honoured when the disable bit is 0
// - inhibit sampled every 0.166ms; the written rate code is not applied
// - position settings unit: command or encoder
// - regeneration limit check only when enabled
// - velocity deviation error; zero threshold disables
// - emergency-stop time rounded up to 2ms
// - third gain held for 0.1ms units
// - third gain is first gain times percent
// - signed torque offset added to command
// - direction compensation added by motion sign
// - second torque limit clamped to motor maximum
// - general filter sampling period from setting
module cmd_cond
  import cmd_cond_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        pulse_in,
  input  wire logic        deviation_counter_clear_input,
  input  wire logic        pulse_inhibit_input,
  input  wire logic        regen_over_limit,
  input  wire logic [15:0] speed_deviation,
  input  wire logic        gain_switch,
  input  wire logic        moving_pos,
  input  wire logic        moving_neg,
  input  wire logic signed [9:0] torque_cmd_in,
  output logic             counter_clear,
  output logic             pulse_gate,
  output logic             unit_encoder,
  output logic             irq,
  output logic signed [9:0] torque_cmd_out,
  output logic      [15:0] pos_gain,
  output logic      [8:0]  torque_limit2
);

  // ******************************************************
  // helpers
  // ******************************************************
  // period in cycles for a 0..3 filter code; other codes mean unfiltered
  function automatic logic [15:0] filt_period(input logic [2:0] code);
    case (code)
      3'h0: filt_period = 16'(T0_CYC);
      3'h1: filt_period = 16'(T1_CYC);
      3'h2: filt_period = 16'(T2_CYC);
      3'h3: filt_period = 16'(T3_CYC);
      default: filt_period = 16'h0001;
    endcase
  endfunction : filt_period

  function automatic logic signed [9:0] sat_pct(input logic signed [11:0] v);
    if (v > $signed({4'h0, TRQ_PCT_MAX}))
      sat_pct = 10'(TRQ_PCT_MAX);
    else if (v < -$signed({4'h0, TRQ_PCT_MAX}))
      sat_pct = -10'(TRQ_PCT_MAX);
    else
      sat_pct = v[9:0];
  endfunction : sat_pct

  // ******************************************************
  // pin synchronisers
  // ******************************************************
  logic [1:0] s_pulse, s_clr, s_inh;
  logic       pulse_d;

  always_ff @(posedge clk) begin
    if (reset) begin
      s_pulse <= 2'h0;
      s_clr   <= 2'h0;
      s_inh   <= 2'h0;
      pulse_d <= 1'b0;
    end else begin
      s_pulse <= {s_pulse[0], pulse_in};
      s_clr   <= {s_clr[0], deviation_counter_clear_input};
      s_inh   <= {s_inh[0], pulse_inhibit_input};
      pulse_d <= s_pulse[1];
    end
  end

  // ******************************************************
  // configuration registers and avalon slave
  // ******************************************************
  logic [2:0]  clr_mode_reg, clr_mode_next;
  logic        inh_dis_reg, inh_dis_next;
  logic [2:0]  inh_rate_reg, inh_rate_next;   // loads code 0 at reset, never written
  logic [2:0]  inh_rate_live_reg, inh_rate_live_next;
  logic        unit_reg, unit_next;
  logic [8:0]  lim2_reg, lim2_next;
  logic [12:0] rate_max_reg, rate_max_next;
  logic        regen_en_reg, regen_en_next;
  logic [14:0] vdev_reg, vdev_next;
  logic [13:0] g3_time_reg, g3_time_next;
  logic [10:0] g3_scale_reg, g3_scale_next;
  logic signed [7:0] ofs_reg, ofs_next, cpos_reg, cpos_next;
  logic signed [7:0] cneg_reg, cneg_next;
  logic [9:0]  estop_reg, estop_next;
  logic [1:0]  gfilt_reg, gfilt_next;
  logic [8:0]  mmax_reg, mmax_next;
  logic [IRQ_W-1:0] stat_reg, stat_next, en_reg, en_next, ev;
  logic [31:0] rd_reg, rd_next;
  logic        wait_reg, wait_next;
  logic [12:0] rate_meas;
  logic [10:0] estop_q;
  logic [15:0] g3_gain;
  logic signed [9:0] trq_reg;

  // one wait state: the answer comes at the second edge of a request
  always_comb begin
    clr_mode_next = clr_mode_reg;
    inh_dis_next  = inh_dis_reg;
    inh_rate_live_next = inh_rate_live_reg;
    unit_next     = unit_reg;
    lim2_next     = lim2_reg;
    rate_max_next = rate_max_reg;
    regen_en_next = regen_en_reg;
    vdev_next     = vdev_reg;
    g3_time_next  = g3_time_reg;
    g3_scale_next = g3_scale_reg;
    ofs_next      = ofs_reg;
    cpos_next     = cpos_reg;
    cneg_next     = cneg_reg;
    estop_next    = estop_reg;
    gfilt_next    = gfilt_reg;
    mmax_next     = mmax_reg;
    en_next       = en_reg;
    rd_next       = rd_reg;
    wait_next     = 1'b1;
    // set wins over the write-one clear
    stat_next     = stat_reg;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      rd_next   = 32'h0;
      if (avs_address == ADDR_CLR_MODE) begin
        rd_next[2:0] = clr_mode_reg;
        if (avs_write && avs_writedata[2:0] <= CLR_EDG_FLT)
          clr_mode_next = avs_writedata[2:0];
      end else if (avs_address == ADDR_INH_CFG) begin
        rd_next = {24'h0, inh_rate_live_reg, 4'h0, inh_dis_reg};
        if (avs_write) begin
          inh_dis_next = avs_writedata[0];
          if (avs_writedata[7:5] <= INH_RATE_RAW)
            inh_rate_live_next = avs_writedata[7:5];
        end
      end else if (avs_address == ADDR_UNIT_SEL) begin
        rd_next[0] = unit_reg;
        if (avs_write) unit_next = avs_writedata[0];
      end else if (avs_address == ADDR_TRQ_LIM2) begin
        rd_next[8:0] = lim2_reg;
        if (avs_write && avs_writedata[8:0] <= TRQ_LIM_MAX)
          lim2_next = avs_writedata[8:0];
      end else if (avs_address == ADDR_RATE_MAX) begin
        rd_next[12:0] = rate_max_reg;
        if (avs_write && avs_writedata[12:0] >= RATE_MAX_MIN
            && avs_writedata[12:0] <= RATE_MAX_RST)
          rate_max_next = avs_writedata[12:0];
      end else if (avs_address == ADDR_REGEN_EN) begin
        rd_next[0] = regen_en_reg;
        if (avs_write) regen_en_next = avs_writedata[0];
      end else if (avs_address == ADDR_VDEV_THR) begin
        rd_next[14:0] = vdev_reg;
        if (avs_write && avs_writedata[14:0] <= VDEV_MAX)
          vdev_next = avs_writedata[14:0];
      end else if (avs_address == ADDR_G3_TIME) begin
        rd_next[13:0] = g3_time_reg;
        if (avs_write && avs_writedata[13:0] <= G3_TIME_MAX)
          g3_time_next = avs_writedata[13:0];
      end else if (avs_address == ADDR_G3_SCALE) begin
        rd_next[10:0] = g3_scale_reg;
        if (avs_write && avs_writedata[10:0] >= G3_SCALE_MIN
            && avs_writedata[10:0] <= G3_SCALE_MAX)
          g3_scale_next = avs_writedata[10:0];
      end else if (avs_address == ADDR_TRQ_OFS) begin
        rd_next = 32'(ofs_reg);
        if (avs_write) ofs_next = 8'(sat_pct(avs_writedata[11:0]));
      end else if (avs_address == ADDR_TRQ_POS) begin
        rd_next = 32'(cpos_reg);
        if (avs_write) cpos_next = 8'(sat_pct(avs_writedata[11:0]));
      end else if (avs_address == ADDR_TRQ_NEG) begin
        rd_next = 32'(cneg_reg);
        if (avs_write) cneg_next = 8'(sat_pct(avs_writedata[11:0]));
      end else if (avs_address == ADDR_ESTOP_MS) begin
        rd_next[9:0] = estop_reg;
        if (avs_write && avs_writedata[9:0] <= ESTOP_MAX)
          estop_next = avs_writedata[9:0];
      end else if (avs_address == ADDR_GEN_FILT) begin
        rd_next[1:0] = gfilt_reg;
        if (avs_write) gfilt_next = avs_writedata[1:0];
      end else if (avs_address == ADDR_MOTOR_MAX) begin
        rd_next[8:0] = mmax_reg;
        if (avs_write && avs_writedata[8:0] <= TRQ_LIM_MAX)
          mmax_next = avs_writedata[8:0];
      end else if (avs_address == ADDR_IRQ_STAT) begin
        rd_next[IRQ_W-1:0] = stat_reg;
      end else if (avs_address == ADDR_IRQ_CLR) begin
        if (avs_write) stat_next = stat_reg & ~avs_writedata[IRQ_W-1:0];
      end else if (avs_address == ADDR_IRQ_EN) begin
        rd_next[IRQ_W-1:0] = en_reg;
        if (avs_write) en_next = avs_writedata[IRQ_W-1:0];
      end else if (avs_address == ADDR_LIVE) begin
        rd_next[3:0] = {counter_clear, pulse_gate, unit_encoder, irq};
      end else if (avs_address == ADDR_RATE_MEAS) begin
        rd_next[12:0] = rate_meas;
      end else if (avs_address == ADDR_ESTOP_Q) begin
        rd_next[10:0] = estop_q;
      end else if (avs_address == ADDR_G3_GAIN) begin
        rd_next[15:0] = g3_gain;
      end else if (avs_address == ADDR_TRQ_OUT) begin
        rd_next = 32'(trq_reg);
      end else begin
        rd_next = BAD_ADDR_DATA;
      end
    end
    stat_next = stat_next | ev;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      clr_mode_reg <= CLR_OFF;
      inh_dis_reg  <= 1'b0;
      inh_rate_live_reg <= 3'h0;
      unit_reg     <= 1'b0;
      lim2_reg     <= MOTOR_MAX_RST;
      rate_max_reg <= RATE_MAX_RST;
      regen_en_reg <= 1'b0;
      vdev_reg     <= 15'h0;
      g3_time_reg  <= 14'h0;
      g3_scale_reg <= G3_SCALE_RST;
      ofs_reg      <= 8'sh0;
      cpos_reg     <= 8'sh0;
      cneg_reg     <= 8'sh0;
      estop_reg    <= 10'h0;
      gfilt_reg    <= 2'h0;
      mmax_reg     <= MOTOR_MAX_RST;
      stat_reg     <= '0;
      en_reg       <= '0;
      rd_reg       <= 32'h0;
      wait_reg     <= 1'b1;
    end else begin
      clr_mode_reg <= clr_mode_next;
      inh_dis_reg  <= inh_dis_next;
      inh_rate_live_reg <= inh_rate_live_next;
      unit_reg     <= unit_next;
      lim2_reg     <= lim2_next;
      rate_max_reg <= rate_max_next;
      regen_en_reg <= regen_en_next;
      vdev_reg     <= vdev_next;
      g3_time_reg  <= g3_time_next;
      g3_scale_reg <= g3_scale_next;
      ofs_reg      <= ofs_next;
      cpos_reg     <= cpos_next;
      cneg_reg     <= cneg_next;
      estop_reg    <= estop_next;
      gfilt_reg    <= gfilt_next;
      mmax_reg     <= mmax_next;
      stat_reg     <= stat_next;
      en_reg       <= en_next;
      rd_reg       <= rd_next;
      wait_reg     <= wait_next;
    end
  end

  // ******************************************************
  // input qualification
  // ******************************************************
  logic [15:0] inh_cnt_reg, inh_cnt_next, clr_cnt_reg, clr_cnt_next;
  logic        inh_f_reg, inh_f_next, clr_f_reg, clr_f_next;
  logic        clr_prev_reg, clr_prev_next, clr_out_next, gate_next;
  logic        clr_lvl;

  // inhibit rate is a power-cycle setting: latched copy loads code 0 at reset and never takes the written rate
  always_ff @(posedge clk) begin
    if (reset) inh_rate_reg <= 3'h0;
    else       inh_rate_reg <= inh_rate_next;
  end
  assign inh_rate_next = inh_rate_reg;

  always_comb begin
    inh_cnt_next = inh_cnt_reg + 16'h0001;
    inh_f_next   = inh_f_reg;
    if (inh_cnt_reg + 16'h0001 >= filt_period(inh_rate_reg)) begin
      inh_cnt_next = 16'h0;
      inh_f_next   = s_inh[1];
    end
    clr_cnt_next = clr_cnt_reg + 16'h0001;
    clr_f_next   = clr_f_reg;
    if (clr_cnt_reg + 16'h0001 >= filt_period({1'b0, gfilt_reg})) begin
      clr_cnt_next = 16'h0;
      clr_f_next   = s_clr[1];
    end
    // filtered modes read the sampled copy, raw modes the synchroniser
    clr_lvl = (clr_mode_reg == CLR_LVL_FLT || clr_mode_reg == CLR_EDG_FLT)
              ? clr_f_reg : s_clr[1];
    clr_prev_next = clr_lvl;
    case (clr_mode_reg)
      CLR_LVL_RAW, CLR_LVL_FLT: clr_out_next = clr_lvl;
      CLR_EDG_RAW, CLR_EDG_FLT: clr_out_next = clr_lvl & ~clr_prev_reg;
      default:                  clr_out_next = 1'b0;
    endcase
    gate_next = inh_dis_reg | ~inh_f_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      inh_cnt_reg   <= 16'h0;
      clr_cnt_reg   <= 16'h0;
      inh_f_reg     <= 1'b0;
      clr_f_reg     <= 1'b0;
      clr_prev_reg  <= 1'b0;
      counter_clear <= 1'b0;
      pulse_gate    <= 1'b1;
      unit_encoder  <= 1'b0;
    end else begin
      inh_cnt_reg   <= inh_cnt_next;
      clr_cnt_reg   <= clr_cnt_next;
      inh_f_reg     <= inh_f_next;
      clr_f_reg     <= clr_f_next;
      clr_prev_reg  <= clr_prev_next;
      counter_clear <= clr_out_next;
      pulse_gate    <= gate_next;
      unit_encoder  <= unit_reg;
    end
  end

  // ******************************************************
  // protection checks, gain and torque path
  // ******************************************************
  logic [15:0] ms_cnt_reg, ms_cnt_next, tk_cnt_reg, tk_cnt_next;
  logic [12:0] pcnt_reg, pcnt_next, meas_reg, meas_next;
  logic [13:0] g3_cnt_reg, g3_cnt_next;
  gain_state_t g_reg, g_next;
  logic [15:0] gain_next;
  logic signed [11:0] sum;
  logic [8:0]  lim_next;
  logic        ms_tick;
  logic [25:0] prod;

  assign ms_tick   = (ms_cnt_reg == 16'(MS_CYC - 1));
  assign rate_meas = meas_reg;
  // round up to the next 2 ms step
  assign estop_q   = 11'(estop_reg) + 11'(estop_reg[0]);
  assign prod      = 26'(G1_GAIN_RST) * 26'(g3_scale_reg);
  assign g3_gain   = 16'(prod / 26'(PCT_DIV));

  always_comb begin
    ms_cnt_next = ms_tick ? 16'h0 : ms_cnt_reg + 16'h0001;
    // edges per millisecond equal kilopulses per second
    pcnt_next = (ms_tick ? 13'h0 : pcnt_reg)
                + 13'(s_pulse[1] & ~pulse_d & pulse_gate);
    meas_next = ms_tick ? pcnt_reg : meas_reg;
    ev = '0;
    ev[IRQ_RATE]  = ms_tick && (pcnt_reg > rate_max_reg);
    ev[IRQ_REGEN] = regen_en_reg && regen_over_limit;
    ev[IRQ_VDEV]  = (vdev_reg != 15'h0)
                    && (speed_deviation > 16'(vdev_reg));
    ev[IRQ_CLR]   = clr_out_next & ~counter_clear;
    // three-step switching: first, third for a set time, then second
    tk_cnt_next = (tk_cnt_reg == 16'(TICK_CYC - 1)) ? 16'h0
                  : tk_cnt_reg + 16'h0001;
    g3_cnt_next = g3_cnt_reg;
    g_next      = g_reg;
    case (g_reg)
      G_FIRST: begin
        if (gain_switch) begin
          g_next      = (g3_time_reg == 14'h0) ? G_SECOND : G_THIRD;
          g3_cnt_next = g3_time_reg;
        end
      end
      G_THIRD: begin
        if (!gain_switch) g_next = G_FIRST;
        else if (tk_cnt_reg == 16'h0) begin
          g3_cnt_next = g3_cnt_reg - 14'h0001;
          if (g3_cnt_reg == 14'h0001) g_next = G_SECOND;
        end
      end
      default: if (!gain_switch) g_next = G_FIRST;
    endcase
    gain_next = (g_next == G_THIRD) ? g3_gain : G1_GAIN_RST;
    sum = 12'(torque_cmd_in) + 12'(ofs_reg);
    if (moving_pos)      sum = sum + 12'(cpos_reg);
    else if (moving_neg) sum = sum + 12'(cneg_reg);
    lim_next = (lim2_reg > mmax_reg) ? mmax_reg : lim2_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ms_cnt_reg     <= 16'h0;
      tk_cnt_reg     <= 16'h0;
      pcnt_reg       <= 13'h0;
      meas_reg       <= 13'h0;
      g3_cnt_reg     <= 14'h0;
      g_reg          <= G_FIRST;
      pos_gain       <= G1_GAIN_RST;
      trq_reg        <= 10'sh0;
      torque_limit2  <= MOTOR_MAX_RST;
      irq            <= 1'b0;
    end else begin
      ms_cnt_reg     <= ms_cnt_next;
      tk_cnt_reg     <= tk_cnt_next;
      pcnt_reg       <= pcnt_next;
      meas_reg       <= meas_next;
      g3_cnt_reg     <= g3_cnt_next;
      g_reg          <= g_next;
      pos_gain       <= gain_next;
      trq_reg        <= sum[9:0];
      torque_limit2  <= lim_next;
      irq            <= |(stat_next & en_next);
    end
  end

  assign torque_cmd_out  = trq_reg;
  assign avs_readdata    = rd_reg;
  assign avs_waitrequest = wait_reg;

endmodule : cmd_cond

// ===== bench/cmd_cond_chk.sv
// checker: port-level assertions for the conditioning block
module cmd_cond_chk
  import cmd_cond_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        deviation_counter_clear_input,
  input wire logic        counter_clear
);
  timeunit 1ns / 1ns;
  logic [2:0] mode_reg;
  wire        pin     = deviation_counter_clear_input;
  wire        off_md  = mode_reg == CLR_OFF;
  wire        lvl_raw = mode_reg == CLR_LVL_RAW;
  wire        edg_raw = mode_reg == CLR_EDG_RAW;
  wire        edg_any = edg_raw || mode_reg == CLR_EDG_FLT;
  // shadow of the clear mode; bad codes are dropped as the design does
  always_ff @(posedge clk) begin
    if (reset)
      mode_reg <= CLR_OFF;
    else if (avs_write && !avs_waitrequest && avs_address == ADDR_CLR_MODE
             && avs_writedata < 32'h5)
      mode_reg <= avs_writedata[2:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered");
  chk_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  chk_wait_cause: assert property ($fell(avs_waitrequest)
    |-> $past(avs_read) || $past(avs_write)) else $error("stray answer");
  chk_bad_read: assert property (avs_read && !avs_waitrequest
    && avs_address == 8'hfc |-> avs_readdata == BAD_ADDR_DATA)
    else $error("unmapped read data wrong");
  chk_clr_off: assert property (off_md && $past(off_md, 3)
    |-> !counter_clear) else $error("clear while disabled");
  chk_clr_level: assert property (lvl_raw && $past(lvl_raw, 3)
    |-> counter_clear == $past(pin, 3)) else $error("level clear wrong");
  chk_edge_once: assert property (edg_any && counter_clear
    |=> !counter_clear) else $error("edge clear too long");
  chk_edge_cause: assert property (edg_raw && $past(edg_raw, 4)
    && counter_clear |-> $past(pin, 3) && !$past(pin, 4))
    else $error("edge clear without edge");
  cover property (lvl_raw && counter_clear);
  cover property (edg_any && counter_clear);
  cover property (avs_read && !avs_waitrequest);
endmodule : cmd_cond_chk

bind cmd_cond cmd_cond_chk chk (.clk, .reset, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .deviation_counter_clear_input, .counter_clear);

// ===== bench/pulse_host.sv
// partner: motion controller model that sends command pulses
module pulse_host (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [7:0] half,
  output logic            pulse_in
);
  timeunit 1ns / 1ns;
  logic [7:0] cnt_reg = 8'h00;
  wire        flip    = cnt_reg + 8'h01 >= half;
  initial pulse_in = 1'b0;
  // square wave, low between bursts; each level lasts half clock cycles
  always @(posedge clk) begin
    cnt_reg <= (!run || flip) ? 8'h00 : cnt_reg + 8'h01;
    pulse_in <= run && (flip ? !pulse_in : pulse_in);
  end
endmodule : pulse_host

// ===== bench/cmd_cond_tb.sv
// testbench: conditioning block against a bench model
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module cmd_cond_tb
  import cmd_cond_pkg::*;
;
  timeunit 1ns / 1ns;
  logic clk, reset, avs_read, avs_write, avs_waitrequest, pulse_in, run;
  logic deviation_counter_clear_input, pulse_inhibit_input, regen_over_limit;
  logic gain_switch, moving_pos, moving_neg, counter_clear, pulse_gate, irq;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] speed_deviation, pos_gain;
  logic [8:0]  torque_limit2;
  logic signed [9:0] torque_cmd_in, torque_cmd_out;
  integer seed, n_errors = 0, n_checks = 0, cyc = 0;
  int i, k, v, e, en, cnt;
  int w[6];
  logic [7:0] wa[6] = '{ADDR_G3_SCALE, ADDR_TRQ_OFS, ADDR_TRQ_POS,
                        ADDR_TRQ_NEG, ADDR_TRQ_LIM2, ADDR_MOTOR_MAX};
  cmd_cond uut (.clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .pulse_in,
    .deviation_counter_clear_input, .pulse_inhibit_input, .regen_over_limit,
    .speed_deviation, .gain_switch, .moving_pos, .moving_neg, .torque_cmd_in,
    .counter_clear, .pulse_gate, .unit_encoder(), .irq, .torque_cmd_out,
    .pos_gain, .torque_limit2);
  pulse_host host (.clk, .run, .half(8'h14), .pulse_in);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard: a stuck run fails
  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      n_errors++;
      stop_test();
    end
  end
  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction : rnd
  // one bus cycle; the edge first keeps release and next raise apart
  task automatic bus(input logic wr, input logic [7:0] a, input int d);
    @(posedge clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input int x);
    bus(1'b0, a, 0);
    `CHK(rd, 32'(x))
  endtask : rchk
  task automatic ev(input int x);
    repeat (3) @(posedge clk);
    rchk(ADDR_IRQ_STAT, x);
    `CHK(irq, 1'((x & en) != 0))
  endtask : ev
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial begin
    seed = 32'hdae0;
    {reset, run, avs_read, avs_write, regen_over_limit, gain_switch} = 6'h20;
    {moving_pos, moving_neg, pulse_inhibit_input} = 3'h0;
    deviation_counter_clear_input = 1'b0;
    {avs_address, avs_writedata, speed_deviation, torque_cmd_in} = '0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rchk(ADDR_RATE_MAX, RATE_MAX_RST);
    rchk(8'hfc, BAD_ADDR_DATA);
    `CHK(torque_limit2, MOTOR_MAX_RST)
    // stop time: example, top, then random
    for (i = 0; i < 6; i++) begin
      v = i == 0 ? 11 : i == 1 ? 1000 : rnd(1001);
      bus(1'b1, ADDR_ESTOP_MS, v);
      rchk(ADDR_ESTOP_Q, (v + 1) / 2 * 2);
    end
    // gain scale, torque offsets, limit
    for (i = 0; i < 6; i++) begin
      w = '{i == 0 ? 50 : i == 1 ? 1000 : 50 + rnd(951), rnd(201) - 100,
            rnd(201) - 100, rnd(201) - 100, rnd(501), rnd(501)};
      v = rnd(201) - 100;
      for (k = 0; k < 6; k++)
        bus(1'b1, wa[k], w[k]);
      torque_cmd_in <= 10'(v);
      {moving_neg, moving_pos} <= 2'(i % 3);
      e = v + w[1] + (i % 3 == 1 ? w[2] : i % 3 == 2 ? w[3] : 0);
      repeat (4) @(posedge clk);
      `CHK(torque_cmd_out, 10'(e))
      `CHK(torque_limit2, 9'(w[4] < w[5] ? w[4] : w[5]))
      rchk(ADDR_G3_GAIN, G1_GAIN_RST * w[0] / 100);
    end
    bus(1'b1, ADDR_G3_TIME, 2);
    gain_switch <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(pos_gain, 16'(G1_GAIN_RST * w[0] / 100))
    repeat (4100) @(posedge clk);
    `CHK(pos_gain, G1_GAIN_RST)
    // events latch only when armed
    en = 15;
    bus(1'b1, ADDR_IRQ_EN, en);
    bus(1'b1, ADDR_REGEN_EN, 0);
    bus(1'b1, ADDR_VDEV_THR, 0);
    regen_over_limit <= 1'b1;
    speed_deviation <= 16'h01f4;
    ev(0);
    bus(1'b1, ADDR_VDEV_THR, 500);
    ev(0);
    bus(1'b1, ADDR_VDEV_THR, 499);
    ev(4);
    bus(1'b1, ADDR_REGEN_EN, 1);
    ev(6);
    {regen_over_limit, speed_deviation} <= '0;
    bus(1'b1, ADDR_IRQ_CLR, 15);
    ev(0);
    // each clear mode, irq masked
    en = 0;
    bus(1'b1, ADDR_IRQ_EN, en);
    for (i = 0; i < 5; i++) begin
      bus(1'b1, ADDR_CLR_MODE, i);
      cnt = 0;
      for (k = 1; k >= 0; k--) begin
        deviation_counter_clear_input <= k[0];
        repeat (3500) begin
          @(posedge clk);
          cnt += counter_clear;
        end
      end
      `CHK(cnt > 0, i > 0)
      if (i != 2)
        `CHK(cnt, i == 1 ? 3500 : i > 2)
    end
    ev(8);
    en = 8;
    bus(1'b1, ADDR_IRQ_EN, en);
    ev(8);
    bus(1'b1, ADDR_IRQ_CLR, 8);
    ev(0);
    // inhibit on, then off; pulses at 2x minimum max
    bus(1'b1, ADDR_INH_CFG, 0);
    pulse_inhibit_input <= 1'b1;
    repeat (T0_CYC + 8) @(posedge clk);
    `CHK(pulse_gate, 1'b0)
    bus(1'b1, ADDR_INH_CFG, 1);
    repeat (3) @(posedge clk);
    `CHK(pulse_gate, 1'b1)
    bus(1'b1, ADDR_RATE_MAX, 249);
    rchk(ADDR_RATE_MAX, RATE_MAX_RST);
    bus(1'b1, ADDR_RATE_MAX, RATE_MAX_MIN);
    run <= 1'b1;
    repeat (2 * MS_CYC + 100) @(posedge clk);
    run <= 1'b0;
    ev(1);
    stop_test();
  end
endmodule : cmd_cond_tb
